// file: design/cwpg_pkg.sv
`default_nettype none
package cwpg_pkg;
	// register byte offsets
	localparam logic [7:0] OSC_REG_OFS = 8'h00;
	localparam logic [7:0] PLL_REG_OFS = 8'h04;
	localparam logic [7:0] SYS_REG_OFS = 8'h08;
	localparam logic [7:0] PROT_REG_OFS = 8'h0c;
	// oscillator control fields
	localparam int OSC_START_BIT = 0;
	localparam int OSC_STATUS_BIT = 1;
	localparam int OSC_INT_EN_BIT = 2;
	localparam int OSC_EXT_EN_BIT = 3;
	localparam int OSC_PLL_RUN_BIT = 4;
	localparam int OSC_WU_SEL_BIT = 5;
	localparam int OSC_SRC_SEL_BIT = 6;
	localparam int OSC_EXT_CLKIN_BIT = 7;
	localparam int OSC_COUNT_LSB = 8;
	localparam int COUNT_W = 12;
	localparam int COUNT_SHIFT = 4;
	localparam int WU_CNT_W = COUNT_W + COUNT_SHIFT;
	// pll select fields
	localparam int PLL_USE_BIT = 0;
	localparam int PLL_MULT_LSB = 1;
	localparam int PLL_MULT_W = 15;
	localparam logic [14:0] PLL_MULT_X8 = 15'h381e;
	// system clock fields
	localparam int SYS_GEAR_LSB = 0;
	localparam int SYS_PERIPH_BASE_CLOCK_SELECT_BIT = 3;
	localparam int SYS_PRESCALER_SELECT_FIELD_LSB = 4;
	localparam int SYS_SCO_LSB = 8;
	localparam int SEL_W = 3;
	localparam int GEAR_MAX_LOG = 4;
	localparam int PRESCALER_SELECT_FIELD_MAX_LOG = 5;
	// clock output source codes
	localparam logic [1:0] SCO_RESERVED = 2'h0;
	localparam logic [1:0] SCO_SYS_HALF = 2'h1;
	localparam logic [1:0] SCO_SYS = 2'h2;
	localparam logic [1:0] SCO_PRESCALER = 2'h3;
	// write protection
	localparam int PROT_W = 8;
	localparam logic [7:0] PROT_UNLOCK = 8'hc1;
	// warm-up sequencer states, gray along idle-run-done
	typedef enum logic [1:0] {
		WU_IDLE = 2'h0,
		WU_RUN = 2'h1,
		WU_DONE = 2'h3
	} cwpg_wu_state_type;
endpackage : cwpg_pkg
`default_nettype wire

// file: design/cwpg_warmup.sv
`default_nettype none
module cwpg_warmup (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic start,
	input wire logic bypass,
	input wire logic warm_clk,
	input wire logic [cwpg_pkg::COUNT_W-1:0] count_field,
	// status
	output logic busy
);
	cwpg_pkg::cwpg_wu_state_type state;
	logic [cwpg_pkg::WU_CNT_W-1:0] count;
	logic [cwpg_pkg::WU_CNT_W-1:0] target;
	logic warm_prev;
	logic warm_edge;

	assign target = {count_field, {cwpg_pkg::COUNT_SHIFT{1'b0}}};
	assign warm_edge = warm_clk & ~warm_prev;

	always_ff @(posedge clk) begin
		if (reset) begin
			warm_prev <= 1'b0;
		end else begin
			warm_prev <= warm_clk;
		end
	end

	// counter ticks on oscillator edges only
	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else if (start) begin
			count <= '0;
		end else if (state == cwpg_pkg::WU_RUN && warm_edge) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= cwpg_pkg::WU_IDLE;
		end else begin
			case (state)
			cwpg_pkg::WU_IDLE, cwpg_pkg::WU_DONE: begin
				if (start) begin
					state <= cwpg_pkg::WU_RUN;
				end
			end
			cwpg_pkg::WU_RUN: begin
				if (start) begin
					state <= cwpg_pkg::WU_RUN;
				end else if (bypass || count >= target) begin
					state <= cwpg_pkg::WU_DONE;
				end
			end
			default: begin
				state <= cwpg_pkg::WU_IDLE;
			end
			endcase
		end
	end

	assign busy = (state == cwpg_pkg::WU_RUN);

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_wu_done_at_target;
		$fell(busy) |-> $past(bypass) || $past(count) >= $past(target);
	endproperty
	a_wu_done_at_target: assert property (p_wu_done_at_target)
		else $error("warm-up ended before target count");

	property p_wu_osc_clocked;
		busy && !start && !warm_edge |=> $stable(count);
	endproperty
	a_wu_osc_clocked: assert property (p_wu_osc_clocked)
		else $error("warm-up counter moved without oscillator edge");

	sequence s_bypass_start;
		start && bypass;
	endsequence
	property p_wu_bypass;
		s_bypass_start ##1 !start |=> !busy;
	endproperty
	a_wu_bypass: assert property (p_wu_bypass)
		else $error("external clock input did not skip warm-up");
endmodule : cwpg_warmup
`default_nettype wire

// file: design/cwpg_tick_divider.sv
`default_nettype none
module cwpg_tick_divider #(
	parameter int MAX_LOG = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// divider control
	input wire logic tick_in,
	input wire logic [cwpg_pkg::SEL_W-1:0] sel,
	// divided tick
	output logic tick_out
);
	logic [MAX_LOG-1:0] count;
	logic [cwpg_pkg::SEL_W-1:0] active;
	logic [MAX_LOG-1:0] mask;
	logic wrap;

	function automatic logic [MAX_LOG-1:0] period_mask(
		input logic [cwpg_pkg::SEL_W-1:0] s);
		logic [MAX_LOG-1:0] m;
		m = '0;
		for (int i = 0; i < MAX_LOG; i++) begin
			if (i < int'(s)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : period_mask

	assign mask = period_mask(active);
	assign wrap = tick_in && ((count & mask) == mask);

	// new ratio is taken only at a period end
	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
			active <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= wrap;
			if (wrap) begin
				count <= '0;
				active <= sel;
			end else if (tick_in) begin
				count <= count + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_div_switch_boundary;
		$changed(active) |-> $past(wrap);
	endproperty
	a_div_switch_boundary: assert property (p_div_switch_boundary)
		else $error("divider ratio switched mid-period");
endmodule : cwpg_tick_divider
`default_nettype wire

// file: design/cwpg_clock_control.sv
// What this block does
// - warm-up count is 12 bits, compared after shifting left by four
// - writing one to the start bit restarts the warm-up counter from zero
// - read-only warm-up flag reads zero once warm-up is finished
// - warm-up counter advances on oscillator clock edges
// - deep stop exit resets oscillator and pll selects and enables, keeps count
// - after reset the pll is stopped and not selected
// - pll gives eight times oscillator; only multiplier code 0x381e allowed, but the field stores any code written
// - gear divides by 1 to 16, changes take effect after a delay
// - prescaler input is base clock divided per select, undivided at reset
// - clock output select: reserved, half system, system, prescaler input
// - no warm-up wait for an external clock input
// - protect key resets to 0xc1; other values block other writes
`default_nettype none
module cwpg_clock_control (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// source clock levels
	input wire logic internal_osc_clk,
	input wire logic external_osc_clk,
	input wire logic pll_clk,
	// mode event
	input wire logic deep_stop_exit,
	// oscillator and pll control
	output logic internal_osc_enable,
	output logic external_osc_enable,
	output logic pll_run_bit,
	output logic [cwpg_pkg::PLL_MULT_W-1:0] pll_multiplier_field,
	// generated clocks
	output logic sys_clock_tick,
	output logic prescaler_input_tick,
	output logic clock_output_pin
);
	// control fields
	logic warmup_clock_select;
	logic osc_source_select;
	logic external_clock_input;
	logic [cwpg_pkg::COUNT_W-1:0] warmup_count_field;
	logic pll_use_select;
	logic [cwpg_pkg::SEL_W-1:0] gear_select;
	logic periph_base_clock_select;
	logic [cwpg_pkg::SEL_W-1:0] prescaler_select_field;
	logic [1:0] clock_output_select;
	logic [1:0] active_output_select;
	logic [cwpg_pkg::PROT_W-1:0] clock_write_protect;
	// bus decode
	logic wr_en;
	logic rd_setup;
	logic unlocked;
	logic addr_ok;
	logic warmup_start;
	logic warmup_status_flag;
	logic [31:0] next_rdata;
	// clock path
	logic fc_level;
	logic fc_prev;
	logic fc_tick;
	logic sys_tick_int;
	logic periph_tick;
	logic pre_tick_int;
	logic half_phase;

	function automatic logic is_write(input logic [7:0] ofs);
		return wr_en && paddr == ofs;
	endfunction : is_write

	assign wr_en = psel && penable && pready && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign unlocked = clock_write_protect == cwpg_pkg::PROT_UNLOCK;
	assign addr_ok = paddr == cwpg_pkg::OSC_REG_OFS
		|| paddr == cwpg_pkg::PLL_REG_OFS
		|| paddr == cwpg_pkg::SYS_REG_OFS
		|| paddr == cwpg_pkg::PROT_REG_OFS;
	assign warmup_start = unlocked && is_write(cwpg_pkg::OSC_REG_OFS)
		&& pwdata[cwpg_pkg::OSC_START_BIT];

	// apb handshake, no wait states
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	always_comb begin
		next_rdata = '0;
		case (paddr)
		cwpg_pkg::OSC_REG_OFS: begin
			next_rdata[cwpg_pkg::OSC_STATUS_BIT] = warmup_status_flag;
			next_rdata[cwpg_pkg::OSC_INT_EN_BIT] = internal_osc_enable;
			next_rdata[cwpg_pkg::OSC_EXT_EN_BIT] = external_osc_enable;
			next_rdata[cwpg_pkg::OSC_PLL_RUN_BIT] = pll_run_bit;
			next_rdata[cwpg_pkg::OSC_WU_SEL_BIT] = warmup_clock_select;
			next_rdata[cwpg_pkg::OSC_SRC_SEL_BIT] = osc_source_select;
			next_rdata[cwpg_pkg::OSC_EXT_CLKIN_BIT] = external_clock_input;
			next_rdata[cwpg_pkg::OSC_COUNT_LSB +: cwpg_pkg::COUNT_W] =
				warmup_count_field;
		end
		cwpg_pkg::PLL_REG_OFS: begin
			next_rdata[cwpg_pkg::PLL_USE_BIT] = pll_use_select;
			next_rdata[cwpg_pkg::PLL_MULT_LSB +: cwpg_pkg::PLL_MULT_W] =
				pll_multiplier_field;
		end
		cwpg_pkg::SYS_REG_OFS: begin
			next_rdata[cwpg_pkg::SYS_GEAR_LSB +: cwpg_pkg::SEL_W] = gear_select;
			next_rdata[cwpg_pkg::SYS_PERIPH_BASE_CLOCK_SELECT_BIT] = periph_base_clock_select;
			next_rdata[cwpg_pkg::SYS_PRESCALER_SELECT_FIELD_LSB +: cwpg_pkg::SEL_W] =
				prescaler_select_field;
			next_rdata[cwpg_pkg::SYS_SCO_LSB +: 2] = clock_output_select;
		end
		cwpg_pkg::PROT_REG_OFS: begin
			next_rdata[cwpg_pkg::PROT_W-1:0] = clock_write_protect;
		end
		default: begin
			next_rdata = '0;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= next_rdata;
		end
	end

	// protect key is always writable
	always_ff @(posedge clk) begin
		if (reset) begin
			clock_write_protect <= cwpg_pkg::PROT_UNLOCK;
		end else if (is_write(cwpg_pkg::PROT_REG_OFS)) begin
			clock_write_protect <= pwdata[cwpg_pkg::PROT_W-1:0];
		end
	end

	// oscillator control; deep stop exit restores defaults
	always_ff @(posedge clk) begin
		if (reset || deep_stop_exit) begin
			internal_osc_enable <= 1'b1;
			external_osc_enable <= 1'b0;
			pll_run_bit <= 1'b0;
			warmup_clock_select <= 1'b0;
			osc_source_select <= 1'b0;
		end else if (unlocked && is_write(cwpg_pkg::OSC_REG_OFS)) begin
			internal_osc_enable <= pwdata[cwpg_pkg::OSC_INT_EN_BIT];
			external_osc_enable <= pwdata[cwpg_pkg::OSC_EXT_EN_BIT];
			pll_run_bit <= pwdata[cwpg_pkg::OSC_PLL_RUN_BIT];
			warmup_clock_select <= pwdata[cwpg_pkg::OSC_WU_SEL_BIT];
			osc_source_select <= pwdata[cwpg_pkg::OSC_SRC_SEL_BIT];
		end
	end

	// count and clock-input flag survive deep stop
	always_ff @(posedge clk) begin
		if (reset) begin
			warmup_count_field <= '0;
			external_clock_input <= 1'b0;
		end else if (unlocked && is_write(cwpg_pkg::OSC_REG_OFS)) begin
			warmup_count_field <=
				pwdata[cwpg_pkg::OSC_COUNT_LSB +: cwpg_pkg::COUNT_W];
			external_clock_input <= pwdata[cwpg_pkg::OSC_EXT_CLKIN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset || deep_stop_exit) begin
			pll_use_select <= 1'b0;
		end else if (unlocked && is_write(cwpg_pkg::PLL_REG_OFS)) begin
			pll_use_select <= pwdata[cwpg_pkg::PLL_USE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pll_multiplier_field <= '0;
		end else if (unlocked && is_write(cwpg_pkg::PLL_REG_OFS)) begin
			pll_multiplier_field <=
				pwdata[cwpg_pkg::PLL_MULT_LSB +: cwpg_pkg::PLL_MULT_W];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			gear_select <= '0;
			periph_base_clock_select <= 1'b0;
			prescaler_select_field <= '0;
			clock_output_select <= cwpg_pkg::SCO_RESERVED;
		end else if (unlocked && is_write(cwpg_pkg::SYS_REG_OFS)) begin
			gear_select <= pwdata[cwpg_pkg::SYS_GEAR_LSB +: cwpg_pkg::SEL_W];
			periph_base_clock_select <= pwdata[cwpg_pkg::SYS_PERIPH_BASE_CLOCK_SELECT_BIT];
			prescaler_select_field <=
				pwdata[cwpg_pkg::SYS_PRESCALER_SELECT_FIELD_LSB +: cwpg_pkg::SEL_W];
			clock_output_select <= pwdata[cwpg_pkg::SYS_SCO_LSB +: 2];
		end
	end

	// warm-up timer on the chosen oscillator
	cwpg_warmup u_warmup (
		.clk(clk),
		.reset(reset),
		.start(warmup_start),
		.bypass(external_clock_input),
		.warm_clk(warmup_clock_select ? external_osc_clk
			: internal_osc_clk),
		.count_field(warmup_count_field),
		.busy(warmup_status_flag)
	);

	// high-speed clock: oscillator or pll
	always_comb begin
		if (pll_use_select) begin
			fc_level = pll_clk;
		end else if (osc_source_select) begin
			fc_level = external_osc_clk;
		end else begin
			fc_level = internal_osc_clk;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fc_prev <= 1'b0;
		end else begin
			fc_prev <= fc_level;
		end
	end
	assign fc_tick = fc_level & ~fc_prev;

	cwpg_tick_divider #(
		.MAX_LOG(cwpg_pkg::GEAR_MAX_LOG)
	) u_gear (
		.clk(clk),
		.reset(reset),
		.tick_in(fc_tick),
		.sel(gear_select),
		.tick_out(sys_tick_int)
	);

	assign periph_tick = periph_base_clock_select ? sys_tick_int : fc_tick;

	cwpg_tick_divider #(
		.MAX_LOG(cwpg_pkg::PRESCALER_SELECT_FIELD_MAX_LOG)
	) u_prescale (
		.clk(clk),
		.reset(reset),
		.tick_in(periph_tick),
		.sel(prescaler_select_field),
		.tick_out(pre_tick_int)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			sys_clock_tick <= 1'b0;
			prescaler_input_tick <= 1'b0;
		end else begin
			sys_clock_tick <= sys_tick_int;
			prescaler_input_tick <= pre_tick_int;
		end
	end

	// output pin: source changes only while pin is low
	always_ff @(posedge clk) begin
		if (reset) begin
			active_output_select <= cwpg_pkg::SCO_RESERVED;
		end else if (!clock_output_pin) begin
			active_output_select <= clock_output_select;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			half_phase <= 1'b0;
			clock_output_pin <= 1'b0;
		end else begin
			if (sys_tick_int) begin
				half_phase <= ~half_phase;
			end
			case (active_output_select)
			cwpg_pkg::SCO_SYS_HALF: begin
				if (sys_tick_int && half_phase) begin
					clock_output_pin <= ~clock_output_pin;
				end
			end
			cwpg_pkg::SCO_SYS: begin
				if (sys_tick_int) begin
					clock_output_pin <= ~clock_output_pin;
				end
			end
			cwpg_pkg::SCO_PRESCALER: begin
				if (pre_tick_int) begin
					clock_output_pin <= ~clock_output_pin;
				end
			end
			default: begin
				clock_output_pin <= 1'b0;
			end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_protect_blocks;
		wr_en && !unlocked && paddr == cwpg_pkg::SYS_REG_OFS
			|=> $stable(gear_select) && $stable(clock_output_select);
	endproperty
	a_protect_blocks: assert property (p_protect_blocks)
		else $error("write passed while protected");

	property p_start_sets_busy;
		warmup_start |=> warmup_status_flag;
	endproperty
	a_start_sets_busy: assert property (p_start_sets_busy)
		else $error("warm-up start did not raise status");

	property p_reset_pll_off;
		$past(reset) |-> !pll_run_bit && !pll_use_select
			&& internal_osc_enable && prescaler_select_field == '0;
	endproperty
	a_reset_pll_off: assert property (p_reset_pll_off)
		else $error("pll or prescaler not at reset state");

	sequence s_stop_exit;
		deep_stop_exit && !wr_en;
	endsequence
	property p_stop_exit;
		s_stop_exit |=> !pll_run_bit && !pll_use_select
			&& !external_osc_enable && $stable(warmup_count_field);
	endproperty
	a_stop_exit: assert property (p_stop_exit)
		else $error("deep stop exit restored wrong fields");

	property p_reserved_low;
		active_output_select == cwpg_pkg::SCO_RESERVED
			|=> !clock_output_pin;
	endproperty
	a_reserved_low: assert property (p_reserved_low)
		else $error("clock output toggled on reserved select");

	property p_pin_switch_low;
		$changed(active_output_select) |-> !$past(clock_output_pin);
	endproperty
	a_pin_switch_low: assert property (p_pin_switch_low)
		else $error("output source switched while pin high");
endmodule : cwpg_clock_control
`default_nettype wire

// file: tb/cwpg_clock_control_tb.sv
`default_nettype none
module cwpg_clock_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err;
	logic internal_osc_clk, external_osc_clk, pll_clk, deep_stop_exit;
	logic internal_osc_enable, external_osc_enable, pll_run_bit;
	logic [cwpg_pkg::PLL_MULT_W-1:0] pll_multiplier_field;
	logic sys_clock_tick, prescaler_input_tick, clock_output_pin;
	logic [1:0] osc_div;
	logic osc_q, pin_q;
	int n_osc, n_sys, n_pre, n_pin, n_fail, comparisons, cycles;
	int s, p, c;

	cwpg_clock_control u_dut (
		.clk(clk),
		.reset(reset),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.internal_osc_clk(internal_osc_clk),
		.external_osc_clk(external_osc_clk),
		.pll_clk(pll_clk),
		.deep_stop_exit(deep_stop_exit),
		.internal_osc_enable(internal_osc_enable),
		.external_osc_enable(external_osc_enable),
		.pll_run_bit(pll_run_bit),
		.pll_multiplier_field(pll_multiplier_field),
		.sys_clock_tick(sys_clock_tick),
		.prescaler_input_tick(prescaler_input_tick),
		.clock_output_pin(clock_output_pin)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// sources: internal period 8, external 16, pll 2 clocks
	always @(posedge clk) begin
		osc_div <= osc_div + 2'h1;
		if (osc_div == 2'h3) begin
			internal_osc_clk <= ~internal_osc_clk;
		end
		if (osc_div == 2'h3 && internal_osc_clk) begin
			external_osc_clk <= ~external_osc_clk;
		end
		pll_clk <= ~pll_clk;
	end

	// edge and pulse counters
	always @(posedge clk) begin
		osc_q <= internal_osc_clk;
		pin_q <= clock_output_pin;
		if (internal_osc_clk === 1'b1 && osc_q === 1'b0) n_osc++;
		if (sys_clock_tick === 1'b1) n_sys++;
		if (prescaler_input_tick === 1'b1) n_pre++;
		if (clock_output_pin === 1'b1 && pin_q === 1'b0) n_pin++;
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			$display("[ERR] %0t run too long", $time);
			complete_run();
		end
	end

	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic wait_osc(input int n);
		int st;
		st = n_osc;
		while (n_osc - st < n) @(posedge clk);
	endtask : wait_osc

	task automatic measure(input logic [31:0] sysval);
		int a, b, e;
		wr(cwpg_pkg::SYS_REG_OFS, sysval);
		wait_osc(40);
		a = n_sys;
		b = n_pre;
		e = n_pin;
		wait_osc(64);
		s = n_sys - a;
		p = n_pre - b;
		c = n_pin - e;
	endtask : measure

	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, deep_stop_exit} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{internal_osc_clk, external_osc_clk, pll_clk} = 3'h0;
		osc_div = 2'h0;
		{osc_q, pin_q} = 2'h0;
		{n_osc, n_sys, n_pre, n_pin, n_fail, comparisons, cycles} = '0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// reset values
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0004);
		rdchk(cwpg_pkg::PLL_REG_OFS, 32'h0);
		rdchk(cwpg_pkg::SYS_REG_OFS, 32'h0);
		rdchk(cwpg_pkg::PROT_REG_OFS, 32'h0000_00c1);
		chk({31'h0, err}, 32'h0);
		chk({31'h0, pll_run_bit}, 32'h0);
		// unmapped place
		wr(8'h10, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		rdchk(8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		// warm-up of 2 << 4 oscillator edges
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_0205);
		wait_osc(24);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0206);
		wait_osc(12);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0204);
		// restart sets status again
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_0205);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0206);
		// external clock input skips the wait
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_0285);
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_0285);
		repeat (4) @(posedge clk);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0284);
		// source first, then pll, then deep stop exit
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_02cc);
		measure(32'h0);
		chk(32'(s), 32'd32);
		wr(cwpg_pkg::PLL_REG_OFS, 32'h0000_703c);
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_02fc);
		wr(cwpg_pkg::PLL_REG_OFS, 32'h0000_703d);
		measure(32'h0);
		chk(32'(s), 32'd256);
		chk({17'h0, pll_multiplier_field}, 32'h0000_381e);
		chk({29'h0, internal_osc_enable, external_osc_enable,
			pll_run_bit}, 32'h7);
		deep_stop_exit <= 1'b1;
		@(posedge clk);
		deep_stop_exit <= 1'b0;
		repeat (2) @(posedge clk);
		chk({29'h0, internal_osc_enable, external_osc_enable,
			pll_run_bit}, 32'h4);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0284);
		rdchk(cwpg_pkg::PLL_REG_OFS, 32'h0000_703c);
		wr(cwpg_pkg::PLL_REG_OFS, 32'h0);
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_0204);
		// write protection
		wr(cwpg_pkg::PROT_REG_OFS, 32'h0);
		wr(cwpg_pkg::SYS_REG_OFS, 32'h0000_0004);
		wr(cwpg_pkg::OSC_REG_OFS, 32'h0000_000c);
		rdchk(cwpg_pkg::SYS_REG_OFS, 32'h0);
		rdchk(cwpg_pkg::OSC_REG_OFS, 32'h0000_0204);
		rdchk(cwpg_pkg::PROT_REG_OFS, 32'h0);
		wr(cwpg_pkg::PROT_REG_OFS, 32'h0000_00c1);
		// gear divider, settings 0 to 4
		for (int g = 0; g < 5; g++) begin
			measure(32'(g));
			chk(32'(s), 32'(64 >> g));
		end
		// prescaler divider, settings 0 to 5
		for (int k = 0; k < 6; k++) begin
			measure(32'(k) << 4);
			chk(32'(p), 32'(64 >> k));
		end
		// clock output source codes
		measure(32'h0000_0010);
		chk(32'(c), 32'h0);
		chk({31'h0, clock_output_pin}, 32'h0);
		measure(32'h0000_0110);
		chk(32'(c), 32'd16);
		measure(32'h0000_0210);
		chk(32'(c), 32'd32);
		measure(32'h0000_0310);
		chk(32'(c), 32'd16);
		measure(32'h0000_0309);
		chk(32'(c), 32'd16);
		complete_run();
	end
endmodule : cwpg_clock_control_tb
`default_nettype wire
